// File: rtl/cdtc_pkg.sv
// constants of the display timing and address controller
// assumes a byte addressed register port on the pixel clock
//
// Notes on behaviour
// - status bit 0 shows live vertical blank
// - sticky blank bit cleared by writing one
// - status bits 2,3 give line, frame parity
// - horizontal total spans whole line, character units
// - horizontal display end sets visible character count
// - hsync at character position plus pixel delay
// - hsync width in characters, bit 23 polarity
// - vertical total spans whole frame in lines
// - vertical display end sets visible line count
// - vsync starts at given line, width lines
// - vsync polarity bit 23, one is negative
// - line interrupt when raster reaches compare line
// - current line readable in bits 26:16
// - render trigger high inside start..end window
// - base address in 64-bit words, software aligns
// - pending flag rises on base write touching bytes 0-2, falls at scan-out
// - lock bit stops internal base, tile update
// - flip at vertical blank or any horizontal blank
// - bit 15 tiled enable, bits 10:8 alignment
// - tiled: physical base, start line mod 32
// - linear: add line pitch at each line end
// - 21-bit read-only frame counter
package cdtc_pkg;
  // ******************************
  // register byte offsets
  // ******************************
  localparam logic [11:0] OFF_STATUS   = 12'h05C;
  localparam logic [11:0] OFF_H_TOTAL  = 12'h200;
  localparam logic [11:0] OFF_H_SYNC   = 12'h204;
  localparam logic [11:0] OFF_V_TOTAL  = 12'h208;
  localparam logic [11:0] OFF_V_SYNC   = 12'h20C;
  localparam logic [11:0] OFF_VLINE    = 12'h210;
  localparam logic [11:0] OFF_FRAME    = 12'h214;
  localparam logic [11:0] OFF_TRIG     = 12'h218;
  localparam logic [11:0] OFF_BASE     = 12'h224;
  localparam logic [11:0] OFF_ADDR_CTL = 12'h228;
  localparam logic [11:0] OFF_PITCH    = 12'h22C;
  // ******************************
  // writable bits of each register
  // ******************************
  localparam logic [31:0] MASK_H_TOTAL  = 32'h00FF01FF;
  localparam logic [31:0] MASK_H_SYNC   = 32'h00BF0FFF;
  localparam logic [31:0] MASK_V_TOTAL  = 32'h07FF07FF;
  localparam logic [31:0] MASK_V_SYNC   = 32'h009F07FF;
  localparam logic [31:0] MASK_VLINE    = 32'h000007FF;
  localparam logic [31:0] MASK_TRIG     = 32'h07FF07FF;
  localparam logic [31:0] MASK_BASE     = 32'h01FFFFFF;
  localparam logic [31:0] MASK_ADDR_CTL = 32'h0001871F;
  localparam logic [31:0] MASK_PITCH    = 32'h000003FF;
  localparam logic [31:0] RESET_VALUE   = 32'h00000000;
  // ******************************
  // field positions
  // ******************************
  localparam int ST_VBLANK    = 0;
  localparam int ST_SEEN      = 1;
  localparam int ST_LINE_PAR  = 2;
  localparam int ST_FRAME_PAR = 3;
  localparam int HI_LSB       = 16;
  localparam int HS_DELAY_LSB = 0;
  localparam int HS_CHAR_LSB  = 3;
  localparam int POL_BIT      = 23;
  localparam int TRIG_BIT     = 31;
  localparam int PEND_BIT     = 30;
  localparam int LOCK_BIT     = 31;
  localparam int TILE_EN_BIT  = 15;
  localparam int FLIP_BIT     = 16;
  localparam int ALIGN_LSB    = 8;
  // ******************************
  // tiled addressing constants, in 64-bit words
  // ******************************
  localparam logic [24:0] TILE_ROW_STEP  = 25'h0000008;
  localparam logic [24:0] TILE_BACK_STEP = 25'h0000078;
  localparam logic [3:0]  TILE_LAST_LINE = 4'hF;
endpackage

// File: rtl/cdtc_display_timing.sv
// display timing, raster status and display base address generator
// assumes clk is the pixel clock and a simple byte addressed register port
`timescale 1ns/10ps
module cdtc_display_timing
  import cdtc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic [3:0]  reg_be,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  // monitor timing
  output logic             hsync,
  output logic             vsync,
  output logic             hblank,
  output logic             vblank,
  // events and address
  output logic             line_irq,
  output logic             render_line_trigger,
  output logic      [24:0] fetch_addr
);

  // ******************************
  // register port helpers
  // ******************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // checkerboard bit picked by the surface alignment code
  function automatic logic [24:0] checker_bit(input logic [2:0] align);
    logic [24:0] r;
    r = 25'h0000000;
    unique case (align)
      3'h0: r = 25'h0000008;
      3'h1: r = 25'h0000100;
      3'h2: r = 25'h0000200;
      3'h3: r = 25'h0000400;
      3'h4: r = 25'h0000800;
      default: r = 25'h0000008;
    endcase
    return r;
  endfunction

  logic [31:0] h_total_reg, h_sync_reg, v_total_reg, v_sync_reg;
  logic [31:0] vline_reg, trig_reg, base_reg, addr_ctl_reg, pitch_reg;
  logic        lock_reg;
  logic        seen_reg;
  logic        pending_reg;
  logic [8:0]  h_char_reg;
  logic [2:0]  h_pix_reg;
  logic [10:0] v_line_reg;
  logic [20:0] frame_reg;
  logic [8:0]  hs_cnt_reg;
  logic        hblank_q_reg, vblank_q_reg;
  logic [24:0] active_base_reg, scan_addr_reg;
  logic [4:0]  active_tile_reg, tile_cnt_reg;
  logic        new_base_reg;

  wire logic wr_hit = reg_wr && (reg_be != 4'h0);
  wire logic wr_base = wr_hit && reg_addr == OFF_BASE;
  wire logic wr_ctl  = wr_hit && reg_addr == OFF_ADDR_CTL;
  wire logic [31:0] base_merged = merge({lock_reg, pending_reg, base_reg[29:0]}, reg_wdata, reg_be);
  wire logic [31:0] ctl_merged  = merge({lock_reg, pending_reg, addr_ctl_reg[29:0]}, reg_wdata, reg_be);

  // ******************************
  // raster counters
  // ******************************
  wire logic [8:0]  h_total  = h_total_reg[8:0];
  wire logic [7:0]  h_disp   = h_total_reg[HI_LSB +: 8];
  wire logic [10:0] v_total  = v_total_reg[10:0];
  wire logic [10:0] v_disp   = v_total_reg[HI_LSB +: 11];
  wire logic line_start = h_char_reg == 9'h000 && h_pix_reg == 3'h0;
  wire logic line_end   = h_pix_reg == 3'h7 && h_char_reg >= h_total;
  wire logic frame_end  = line_end && v_line_reg >= v_total;
  wire logic in_hblank  = h_char_reg >= {1'b0, h_disp};
  wire logic in_vblank  = v_line_reg >= v_disp;
  wire logic hblank_rise = in_hblank && !hblank_q_reg;
  wire logic vblank_rise = in_vblank && !vblank_q_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      h_pix_reg  <= 3'h0;
      h_char_reg <= 9'h000;
    end else if (line_end) begin
      h_pix_reg  <= 3'h0;
      h_char_reg <= 9'h000;
    end else begin
      h_pix_reg  <= h_pix_reg + 3'h1;
      if (h_pix_reg == 3'h7) begin
        h_char_reg <= h_char_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      v_line_reg <= 11'h000;
    end else if (frame_end) begin
      v_line_reg <= 11'h000;
    end else if (line_end) begin
      v_line_reg <= v_line_reg + 11'h001;
    end
  end

  // free-running count wraps by width on purpose
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_reg <= 21'h000000;
    end else if (frame_end) begin
      frame_reg <= frame_reg + 21'h000001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hblank_q_reg <= 1'b0;
      vblank_q_reg <= 1'b0;
      hblank       <= 1'b0;
      vblank       <= 1'b0;
    end else begin
      hblank_q_reg <= in_hblank;
      vblank_q_reg <= in_vblank;
      hblank       <= in_hblank;
      vblank       <= in_vblank;
    end
  end

  // ******************************
  // sync generation
  // ******************************
  wire logic hs_start = h_char_reg == h_sync_reg[HS_CHAR_LSB +: 9]
                     && h_pix_reg == h_sync_reg[HS_DELAY_LSB +: 3];
  wire logic [10:0] vs_off = v_line_reg - v_sync_reg[10:0];
  wire logic vs_active = v_line_reg >= v_sync_reg[10:0]
                      && vs_off < {6'h00, v_sync_reg[HI_LSB +: 5]};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hs_cnt_reg <= 9'h000;
    end else if (hs_start) begin
      hs_cnt_reg <= {h_sync_reg[HI_LSB +: 6], 3'h0};
    end else if (hs_cnt_reg != 9'h000) begin
      hs_cnt_reg <= hs_cnt_reg - 9'h001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hsync <= 1'b0;
      vsync <= 1'b0;
    end else begin
      hsync <= (hs_cnt_reg != 9'h000) ^ h_sync_reg[POL_BIT];
      vsync <= vs_active ^ v_sync_reg[POL_BIT];
    end
  end

  // ******************************
  // line events
  // ******************************
  wire logic in_window = v_line_reg >= trig_reg[10:0] && v_line_reg <= trig_reg[HI_LSB +: 11];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_irq            <= 1'b0;
      render_line_trigger <= 1'b0;
    end else begin
      line_irq            <= line_start && v_line_reg == vline_reg[10:0];
      render_line_trigger <= in_window;
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seen_reg <= 1'b0;
    end else if (vblank_rise) begin
      seen_reg <= 1'b1;
    end else if (wr_hit && reg_addr == OFF_STATUS && reg_be[0] && reg_wdata[ST_SEEN]) begin
      seen_reg <= 1'b0;
    end
  end

  // ******************************
  // software registers
  // ******************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      h_total_reg  <= RESET_VALUE;
      h_sync_reg   <= RESET_VALUE;
      v_total_reg  <= RESET_VALUE;
      v_sync_reg   <= RESET_VALUE;
      vline_reg    <= RESET_VALUE;
      trig_reg     <= RESET_VALUE;
      base_reg     <= RESET_VALUE;
      addr_ctl_reg <= RESET_VALUE;
      pitch_reg    <= RESET_VALUE;
      lock_reg     <= 1'b0;
    end else if (wr_hit) begin
      unique case (reg_addr)
        OFF_H_TOTAL: h_total_reg <= merge(h_total_reg, reg_wdata, reg_be) & MASK_H_TOTAL;
        OFF_H_SYNC:  h_sync_reg  <= merge(h_sync_reg, reg_wdata, reg_be) & MASK_H_SYNC;
        OFF_V_TOTAL: v_total_reg <= merge(v_total_reg, reg_wdata, reg_be) & MASK_V_TOTAL;
        OFF_V_SYNC:  v_sync_reg  <= merge(v_sync_reg, reg_wdata, reg_be) & MASK_V_SYNC;
        OFF_VLINE:   vline_reg   <= merge(vline_reg, reg_wdata, reg_be) & MASK_VLINE;
        OFF_TRIG:    trig_reg    <= merge(trig_reg, reg_wdata, reg_be) & MASK_TRIG;
        OFF_PITCH:   pitch_reg   <= merge(pitch_reg, reg_wdata, reg_be) & MASK_PITCH;
        OFF_BASE: begin
          base_reg <= base_merged & MASK_BASE;
          lock_reg <= base_merged[LOCK_BIT];
        end
        OFF_ADDR_CTL: begin
          addr_ctl_reg <= ctl_merged & MASK_ADDR_CTL;
          lock_reg     <= ctl_merged[LOCK_BIT];
        end
        default: ;
      endcase
    end
  end

  // ******************************
  // buffer flip
  // ******************************
  wire logic flip_sel  = addr_ctl_reg[FLIP_BIT];
  wire logic tiled     = addr_ctl_reg[TILE_EN_BIT];
  wire logic flip_evt  = flip_sel ? hblank_rise : vblank_rise;
  wire logic take      = flip_evt && !lock_reg;
  wire logic scan_load = frame_end || (line_end && flip_sel && new_base_reg);
  // only the last write matters; base written under lock waits for unlock
  wire logic base_write_any = wr_base && reg_be[3:0] != 4'h0 && (reg_be[2:0] != 3'h0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_base_reg <= 25'h0000000;
      active_tile_reg <= 5'h00;
      new_base_reg    <= 1'b0;
    end else if (take) begin
      active_base_reg <= base_reg[24:0];
      active_tile_reg <= addr_ctl_reg[4:0];
      new_base_reg    <= pending_reg;
    end else if (scan_load) begin
      new_base_reg    <= 1'b0;
    end
  end

  // a base write in the cycle of the scan load keeps the flag up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_reg <= 1'b0;
    end else if (base_write_any) begin
      pending_reg <= 1'b1;
    end else if (scan_load && new_base_reg) begin
      pending_reg <= 1'b0;
    end
  end

  // ******************************
  // display address generation
  // ******************************
  wire logic [24:0] pitch_words = {15'h0000, pitch_reg[9:0]};
  wire logic [24:0] tile_step = (tile_cnt_reg[3:0] == TILE_LAST_LINE)
                              ? (pitch_words << 4) - TILE_BACK_STEP : TILE_ROW_STEP;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scan_addr_reg <= 25'h0000000;
      tile_cnt_reg  <= 5'h00;
    end else if (scan_load) begin
      scan_addr_reg <= active_base_reg;
      tile_cnt_reg  <= active_tile_reg;
    end else if (line_end) begin
      scan_addr_reg <= scan_addr_reg + (tiled ? tile_step : pitch_words);
      tile_cnt_reg  <= tile_cnt_reg + 5'h01;
    end
  end

  // odd tile rows swap halves, keyed to the surface alignment
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch_addr <= 25'h0000000;
    end else begin
      fetch_addr <= scan_addr_reg
                  ^ ((tiled && tile_cnt_reg[4]) ? checker_bit(addr_ctl_reg[ALIGN_LSB +: 3]) : 25'h0000000);
    end
  end

  // ******************************
  // register read
  // ******************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata  <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          OFF_STATUS:   reg_rdata <= {28'h0000000, frame_reg[0], v_line_reg[0], seen_reg, in_vblank};
          OFF_H_TOTAL:  reg_rdata <= h_total_reg;
          OFF_H_SYNC:   reg_rdata <= h_sync_reg;
          OFF_V_TOTAL:  reg_rdata <= v_total_reg;
          OFF_V_SYNC:   reg_rdata <= v_sync_reg;
          OFF_VLINE:    reg_rdata <= {5'h00, v_line_reg, vline_reg[15:0]};
          OFF_FRAME:    reg_rdata <= {11'h000, frame_reg};
          OFF_TRIG:     reg_rdata <= {render_line_trigger, trig_reg[30:0]};
          OFF_BASE:     reg_rdata <= {lock_reg, pending_reg, base_reg[29:0]};
          OFF_ADDR_CTL: reg_rdata <= {lock_reg, pending_reg, addr_ctl_reg[29:0]};
          OFF_PITCH:    reg_rdata <= pitch_reg;
          default:      reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ******************************
  // checks
  // ******************************
  property p_seen_set;
    @(posedge clk) disable iff (!rstn) vblank_rise |=> seen_reg;
  endproperty
  a_seen_set: assert property (p_seen_set) else $error("blank flag not set");

  property p_seen_hold;
    @(posedge clk) disable iff (!rstn)
      seen_reg && !(reg_wr && reg_addr == OFF_STATUS && reg_be[0] && reg_wdata[ST_SEEN]) |=> seen_reg;
  endproperty
  a_seen_hold: assert property (p_seen_hold) else $error("blank flag lost");

  property p_frame_step;
    @(posedge clk) disable iff (!rstn) frame_end |=> frame_reg == $past(frame_reg) + 21'h000001;
  endproperty
  a_frame_step: assert property (p_frame_step) else $error("frame count step wrong");

  property p_line_irq;
    @(posedge clk) disable iff (!rstn) line_irq |-> $past(v_line_reg) == $past(vline_reg[10:0]) && $past(line_start);
  endproperty
  a_line_irq: assert property (p_line_irq) else $error("line interrupt on wrong line");

  property p_hsync_width;
    @(posedge clk) disable iff (!rstn)
      hs_start && h_sync_reg[HI_LSB +: 6] != 6'h00 |=> ##1 hsync == !h_sync_reg[POL_BIT];
  endproperty
  a_hsync_width: assert property (p_hsync_width) else $error("hsync not asserted");

  property p_pending_set;
    @(posedge clk) disable iff (!rstn) base_write_any |=> pending_reg;
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending flag not raised");

  property p_lock_hold;
    @(posedge clk) disable iff (!rstn) lock_reg |=> active_base_reg == $past(active_base_reg);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("base changed under lock");

  property p_trigger;
    @(posedge clk) disable iff (!rstn) $past(rstn) |-> render_line_trigger == $past(in_window);
  endproperty
  a_trigger: assert property (p_trigger) else $error("render trigger mismatch");

endmodule

// File: testbench/cdtc_monitor_model.sv
// display monitor model: measures the sync and blank timing it receives
// assumes it shares the pixel clock and reset of the controller
`timescale 1ns/10ps
module cdtc_monitor_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // timing inputs and expected polarity
  input  wire logic        hsync,
  input  wire logic        vsync,
  input  wire logic        hblank,
  input  wire logic        hpol,
  input  wire logic        vpol,
  // measurements
  output logic      [15:0] line_clks,
  output logic      [15:0] hs_width,
  output logic      [15:0] hs_offset,
  output logic      [15:0] frame_clks,
  output logic      [7:0]  vs_lines
);
  logic        hs_act;
  logic        vs_act;
  logic        hs_q;
  logic        vs_q;
  logic        hb_q;
  logic [15:0] hcnt;
  logic [15:0] wcnt;
  logic [15:0] ocnt;
  logic [15:0] fcnt;
  logic [7:0]  lcnt;
  // polarity one means the pulse is low
  assign hs_act = hsync ^ hpol;
  assign vs_act = vsync ^ vpol;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {hs_q, vs_q, hb_q, hcnt, wcnt, ocnt, fcnt, lcnt} <= '0;
      {line_clks, hs_width, hs_offset, frame_clks, vs_lines} <= '0;
    end else begin
      hs_q <= hs_act;
      vs_q <= vs_act;
      hb_q <= hblank;
      hcnt <= (hs_act && !hs_q) ? 16'h0001 : hcnt + 16'h0001;
      fcnt <= (vs_act && !vs_q) ? 16'h0001 : fcnt + 16'h0001;
      ocnt <= (hblank && !hb_q) ? 16'h0001 : ocnt + 16'h0001;
      wcnt <= hs_act ? wcnt + 16'h0001 : 16'h0000;
      lcnt <= !vs_act ? 8'h00 : lcnt + 8'(hs_act && !hs_q);
      if (hs_act && !hs_q) begin
        line_clks <= hcnt;
        hs_offset <= ocnt;
      end
      if (vs_act && !vs_q) begin
        frame_clks <= fcnt;
      end
      if (hs_q && !hs_act) begin
        hs_width <= wcnt;
      end
      // only whole vsync pulses are reported
      if (vs_q && !vs_act) begin
        vs_lines <= lcnt;
      end
    end
  end
endmodule

// File: testbench/test_cdtc_display_timing.sv
// register level testbench of the display timing controller
// assumes the monitor model and the package; clk is 20 MHz
`timescale 1ns/10ps
module test_cdtc_display_timing
  import cdtc_pkg::*;
;
  logic        clk;
  logic        rstn;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [3:0]  reg_be;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic        hsync;
  logic        vsync;
  logic        hblank;
  logic        vblank;
  logic        line_irq;
  logic        render_line_trigger;
  logic [24:0] fetch_addr;
  logic        hpol;
  logic        vpol;
  logic [15:0] line_clks;
  logic [15:0] hs_width;
  logic [15:0] hs_offset;
  logic [15:0] frame_clks;
  logic [7:0]  vs_lines;
  logic [31:0] f0;
  logic [31:0] f1;
  logic [31:0] s0;
  logic [11:0] offs [9];
  logic [31:0] masks [9];
  int          miscompares;
  int          checks_done;
  int          n_irq;
  int          n_trig;
  int          n_vb;
  int          n_hb;
  int          n;

  cdtc_display_timing dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .hsync(hsync), .vsync(vsync), .hblank(hblank), .vblank(vblank), .line_irq(line_irq),
    .render_line_trigger(render_line_trigger), .fetch_addr(fetch_addr));
  cdtc_monitor_model mon_u (.clk(clk), .rstn(rstn), .hsync(hsync), .vsync(vsync), .hblank(hblank),
    .hpol(hpol), .vpol(vpol), .line_clks(line_clks), .hs_width(hs_width), .hs_offset(hs_offset),
    .frame_clks(frame_clks), .vs_lines(vs_lines));

  // ******************************
  // shared tasks
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_be    <= be;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(32'(reg_rvalid), 32'h00000001);
    d = reg_rdata;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d & m, exp);
  endtask
  // bounded wait, a lost frame counts as a mismatch
  task automatic wait_vb(input logic lvl);
    int k;
    k = 0;
    while (vblank !== lvl && k < 1000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 1000) miscompares++;
  endtask
  task automatic sync_frame();
    wait_vb(1'b1);
    wait_vb(1'b0);
  endtask
  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask
  task automatic finish_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ******************************
  // clock, watchdog and tests
  // ******************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end
  initial begin
    {rstn, reg_addr, reg_wdata, reg_be, reg_wr, reg_rd, hpol, vpol} = '0;
    miscompares = 0;
    checks_done = 0;
    offs  = '{OFF_H_TOTAL, OFF_H_SYNC, OFF_V_TOTAL, OFF_V_SYNC, OFF_VLINE, OFF_TRIG, OFF_BASE,
              OFF_ADDR_CTL, OFF_PITCH};
    masks = '{MASK_H_TOTAL, MASK_H_SYNC, MASK_V_TOTAL, MASK_V_SYNC, MASK_VLINE, MASK_TRIG, MASK_BASE,
              MASK_ADDR_CTL, MASK_PITCH};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // with all zero a one line frame keeps line 0 inside the window
    for (int i = 0; i < 9; i++) rchk(offs[i], 32'hFFFFFFFF, (i == 5) ? 32'h80000000 : RESET_VALUE);
    for (int i = 0; i < 9; i++) begin
      if (i != 6 && i != 7) begin
        wr(offs[i], 32'hFFFFFFFF, 4'hF);
        rchk(offs[i], masks[i], masks[i]);
      end
    end
    wr(12'h100, 32'hFFFFFFFF, 4'hF);
    rchk(12'h100, 32'hFFFFFFFF, 32'h00000000);
    wr(OFF_H_TOTAL, 32'h00000000, 4'h4);
    rchk(OFF_H_TOTAL, 32'hFFFFFFFF, 32'h000001FF);
    end_test("registers");
    // second reset drops the huge totals written above
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      hpol <= p[0];
      vpol <= p[0];
      wr(OFF_H_TOTAL, 32'h00020003, 4'hF);
      wr(OFF_H_SYNC, 32'h00010013 | (32'(p) << 23), 4'hF);
      wr(OFF_V_TOTAL, 32'h00060009, 4'hF);
      wr(OFF_V_SYNC, 32'h00020007 | (32'(p) << 23), 4'hF);
      repeat (1000) @(posedge clk);
      check(32'(line_clks), 32'd32);
      check(32'(hs_width), 32'd8);
      check(32'(hs_offset), 32'd4);
      check(32'(frame_clks), 32'd320);
      check(32'(vs_lines), 32'd2);
    end
    end_test("timing");
    wr(OFF_VLINE, 32'h00000003, 4'hF);
    wr(OFF_TRIG, 32'h00040002, 4'hF);
    sync_frame();
    {n_irq, n_trig, n_vb, n_hb} = '0;
    for (int i = 0; i < 320; i++) begin
      @(posedge clk);
      #1;
      n_irq  += int'(line_irq === 1'b1);
      n_trig += int'(render_line_trigger === 1'b1);
      n_vb   += int'(vblank === 1'b1);
      n_hb   += int'(hblank === 1'b1);
    end
    check(n_irq, 1);
    check(n_trig, 96);
    check(n_vb, 128);
    check(n_hb, 160);
    n = 0;
    while (line_irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(32'(n < 400), 32'h00000001);
    rchk(OFF_VLINE, 32'h07FF07FF, 32'h00030003);
    rchk(OFF_TRIG, 32'hFFFFFFFF, 32'h80040002);
    end_test("events");
    sync_frame();
    wr(OFF_STATUS, 32'h00000002, 4'h1);
    rchk(OFF_STATUS, 32'h00000007, 32'h00000000);
    wait_vb(1'b1);
    rchk(OFF_STATUS, 32'h00000007, 32'h00000003);
    wr(OFF_STATUS, 32'h00000000, 4'hF);
    wr(OFF_STATUS, 32'h00000002, 4'h2);
    rchk(OFF_STATUS, 32'h00000003, 32'h00000003);
    repeat (32) @(posedge clk);
    rchk(OFF_STATUS, 32'h00000004, 32'h00000004);
    rd(OFF_FRAME, f0);
    rd(OFF_STATUS, s0);
    check(32'(s0[3]), 32'(f0[0]));
    sync_frame();
    rd(OFF_FRAME, f1);
    check(f1, f0 + 32'h00000001);
    end_test("status");
    wr(OFF_PITCH, 32'h00000005, 4'hF);
    sync_frame();
    wr(OFF_BASE, 32'h00000100, 4'hF);
    rchk(OFF_BASE, 32'hFFFFFFFF, 32'h40000100);
    sync_frame();
    repeat (4) @(posedge clk);
    #1;
    check(32'(fetch_addr), 32'h00000100);
    repeat (32) @(posedge clk);
    #1;
    check(32'(fetch_addr), 32'h00000105);
    rchk(OFF_BASE, 32'hFFFFFFFF, 32'h00000100);
    wr(OFF_BASE, 32'h80000200, 4'hF);
    sync_frame();
    sync_frame();
    repeat (4) @(posedge clk);
    #1;
    check(32'(fetch_addr), 32'h00000100);
    rchk(OFF_ADDR_CTL, 32'hC0000000, 32'hC0000000);
    wr(OFF_BASE, 32'h00000200, 4'hF);
    sync_frame();
    repeat (4) @(posedge clk);
    #1;
    check(32'(fetch_addr), 32'h00000200);
    // line end flips must not wait for the frame end
    wr(OFF_ADDR_CTL, 32'h00010000, 4'hF);
    sync_frame();
    wr(OFF_BASE, 32'h00000300, 4'hF);
    repeat (70) @(posedge clk);
    rchk(OFF_BASE, 32'hFFFFFFFF, 32'h00000300);
    // tiled surface starting in an odd tile row, alignment code 0
    wr(OFF_ADDR_CTL, 32'h00008010, 4'hF);
    wr(OFF_BASE, 32'h00000400, 4'hF);
    sync_frame();
    repeat (4) @(posedge clk);
    #1;
    check(32'(fetch_addr), 32'h00000408);
    repeat (32) @(posedge clk);
    #1;
    check(32'(fetch_addr), 32'h00000400);
    end_test("flip");
    finish_test();
  end
endmodule
